// File: verilog/epd_dev.sv
// Display controller end: command interpreter with busy timing.
`timescale 1ns/1ps
`default_nettype none
`include "epd_defs.svh"
module epd_dev #(
   parameter logic [31:0] RST_BUSY_CYC = `EPD_RST_BUSY_CYC,
   parameter logic [31:0] CLR_BUSY_CYC = `EPD_CLR_BUSY_CYC,
   parameter logic [31:0] DRV_BUSY_CYC = `EPD_DRV_BUSY_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Link.
   epd_link_if.dev link,
   // Applied settings.
   output logic [15:0] gate_mux,
   output logic [7:0] gate_scan,
   output logic [7:0] entry_mode,
   output logic [15:0] x_start,
   output logic [15:0] x_end,
   output logic [15:0] y_start,
   output logic [15:0] y_end,
   output logic [7:0] border_cfg,
   output logic [7:0] temperature_sensor,
   output logic [7:0] update_ctrl,
   output logic [31:0] softstart_cfg,
   output logic deep_sleep_state,
   // Image RAM writes and operations.
   output logic ram_we,
   output logic ram_sel,
   output logic [7:0] ram_data,
   output logic [15:0] ram_x,
   output logic [15:0] ram_y,
   output logic clear_pulse,
   output logic clear_sel,
   output logic drive_pulse
);
   epd_pkg::epd_dev_state_t r_reg;   // Registered state.
   epd_pkg::epd_dev_state_t r_next;  // Next state.
   logic rx_valid;                   // Byte received.
   logic [7:0] rx_byte;              // Received byte.
   logic rx_is_data;                 // Byte was data.
   logic hw_rst;                     // Reset pin held low.

   // Power-up settings, shared by pin reset and software reset.
   function automatic epd_pkg::epd_dev_state_t dev_init();
      epd_pkg::epd_dev_state_t s;
      s = '0;
      return s;
   endfunction : dev_init

   // Starts an operation lasting n cycles with busy high.
   function automatic epd_pkg::epd_dev_state_t start_op(
      input epd_pkg::epd_dev_state_t s, input logic [31:0] n);
      epd_pkg::epd_dev_state_t t;
      t = s;
      t.busy = 1'b1;
      t.busy_cnt = n;
      return t;
   endfunction : start_op

   // Pin synchroniser and deserialiser.
   epd_rx u_rx (
      .mclk(mclk),
      .rstn(rstn),
      .pins({link.res_n, link.sdin, link.dc, link.cs_n, link.sclk}),
      .byte_valid(rx_valid),
      .byte_data(rx_byte),
      .byte_is_data(rx_is_data),
      .hw_rst(hw_rst)
   );

   ////////////////////////////////////////////////////////////////////////
   // Command decode and parameter capture.
   always_comb begin
      r_next = r_reg;
      r_next.ram_we = 1'b0;
      r_next.clr_pulse = 1'b0;
      r_next.drive_pulse = 1'b0;
      // Busy falls when the running operation ends.
      if (r_reg.busy) begin
         r_next.busy_cnt = r_reg.busy_cnt - 32'h1;
         if (r_reg.busy_cnt <= 32'h1) begin
            r_next.busy = 1'b0;
         end
      end
      if (hw_rst) begin
         r_next = dev_init();
      end else if (rx_valid && !r_reg.deep_sleep_state && !r_reg.busy) begin
         if (!rx_is_data) begin
            r_next.cmd = rx_byte;
            r_next.idx = 2'h0;
            if (rx_byte == `EPD_CMD_SWRST) begin
               r_next = start_op(dev_init(), RST_BUSY_CYC);
               r_next.cmd = rx_byte;
            end else if (rx_byte == `EPD_CMD_ACTIVATE) begin
               // Starts the drive: one pulse and a busy spell of DRV_BUSY_CYC cycles, whatever update control holds.
               r_next = start_op(r_next, DRV_BUSY_CYC);
               r_next.drive_pulse = 1'b1;
            end
         end else begin
            if (r_reg.idx != 2'h3) begin
               r_next.idx = r_reg.idx + 2'h1;
            end
            unique case (r_reg.cmd)
               `EPD_CMD_GATE: begin
                  if (!r_reg.idx[1]) begin
                     r_next.gate_mux[{r_reg.idx[0], 3'h0} +: 8] = rx_byte;
                  end else begin
                     r_next.gate_scan = rx_byte;
                  end
               end
               `EPD_CMD_ENTRY: r_next.entry = rx_byte;
               `EPD_CMD_XWIN: begin
                  if (!r_reg.idx[1]) begin
                     r_next.xs[{r_reg.idx[0], 3'h0} +: 8] = rx_byte;
                  end else begin
                     r_next.xe[{r_reg.idx[0], 3'h0} +: 8] = rx_byte;
                  end
               end
               `EPD_CMD_YWIN: begin
                  if (!r_reg.idx[1]) begin
                     r_next.ys[{r_reg.idx[0], 3'h0} +: 8] = rx_byte;
                  end else begin
                     r_next.ye[{r_reg.idx[0], 3'h0} +: 8] = rx_byte;
                  end
               end
               `EPD_CMD_BORDER: r_next.border = rx_byte;
               `EPD_CMD_TEMP: r_next.temp_sel = rx_byte;
               `EPD_CMD_UPDCTRL: r_next.upd_ctrl = rx_byte;
               `EPD_CMD_SOFTSTART: r_next.softstart[{r_reg.idx, 3'h0} +: 8] = rx_byte;
               `EPD_CMD_XCNT: r_next.xc[{r_reg.idx[0], 3'h0} +: 8] = rx_byte;
               `EPD_CMD_YCNT: r_next.yc[{r_reg.idx[0], 3'h0} +: 8] = rx_byte;
               `EPD_CMD_RAM_BW, `EPD_CMD_RAM_RED: begin
                  // Each byte lands at the counter, which then steps.
                  r_next.ram_we = 1'b1;
                  r_next.ram_sel = (r_reg.cmd == `EPD_CMD_RAM_RED);
                  r_next.ram_data = rx_byte;
                  r_next.ram_x = r_reg.xc;
                  r_next.ram_y = r_reg.yc;
                  r_next.xc = r_reg.xc + 16'h1;
               end
               `EPD_CMD_CLR_BW, `EPD_CMD_CLR_RED: begin
                  // Only the fill pattern starts a clear.
                  if (rx_byte == `EPD_FILL_DATA) begin
                     r_next = start_op(r_next, CLR_BUSY_CYC);
                     r_next.clr_pulse = 1'b1;
                     r_next.clr_sel = (r_reg.cmd == `EPD_CMD_CLR_RED);
                  end
               end
               `EPD_CMD_DEEP_SLEEP: r_next.deep_sleep_state = (rx_byte != 8'h00);
               default: ;
            endcase
         end
      end
   end

   // Register the state.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign link.busy = r_reg.busy;
   assign gate_mux = r_reg.gate_mux;
   assign gate_scan = r_reg.gate_scan;
   assign entry_mode = r_reg.entry;
   assign x_start = r_reg.xs;
   assign x_end = r_reg.xe;
   assign y_start = r_reg.ys;
   assign y_end = r_reg.ye;
   assign border_cfg = r_reg.border;
   assign temperature_sensor = r_reg.temp_sel;
   assign update_ctrl = r_reg.upd_ctrl;
   assign softstart_cfg = r_reg.softstart;
   assign deep_sleep_state = r_reg.deep_sleep_state;
   assign ram_we = r_reg.ram_we;
   assign ram_sel = r_reg.ram_sel;
   assign ram_data = r_reg.ram_data;
   assign ram_x = r_reg.ram_x;
   assign ram_y = r_reg.ram_y;
   assign clear_pulse = r_reg.clr_pulse;
   assign clear_sel = r_reg.clr_sel;
   assign drive_pulse = r_reg.drive_pulse;
endmodule : epd_dev
`default_nettype wire

// File: verilog/epd_defs.svh
// Command codes, pin positions, reset values and timing counts for the e-paper link.
`ifndef EPD_DEFS_SVH
`define EPD_DEFS_SVH
// Command codes.
`define EPD_CMD_GATE 8'h01
`define EPD_CMD_SOFTSTART 8'h0C
`define EPD_CMD_DEEP_SLEEP 8'h10
`define EPD_CMD_ENTRY 8'h11
`define EPD_CMD_SWRST 8'h12
`define EPD_CMD_TEMP 8'h18
`define EPD_CMD_ACTIVATE 8'h20
`define EPD_CMD_UPDCTRL 8'h22
`define EPD_CMD_RAM_BW 8'h24
`define EPD_CMD_RAM_RED 8'h26
`define EPD_CMD_BORDER 8'h3C
`define EPD_CMD_XWIN 8'h44
`define EPD_CMD_YWIN 8'h45
`define EPD_CMD_CLR_BW 8'h46
`define EPD_CMD_CLR_RED 8'h47
`define EPD_CMD_XCNT 8'h4E
`define EPD_CMD_YCNT 8'h4F
`define EPD_FILL_DATA 8'hF7
// Pin positions in the sampled pin vector, and its idle value.
`define EPD_PIN_SCLK 0
`define EPD_PIN_CS 1
`define EPD_PIN_DC 2
`define EPD_PIN_SDIN 3
`define EPD_PIN_RES 4
`define EPD_PIN_IDLE 5'h12
// Timing: clock rate, then times in their own units and derived cycles.
`define EPD_CLK_MHZ 100
`define EPD_SCLK_HALF 4'h4
`define EPD_GUARD_CYC 32'h0000_0010
`define EPD_SWRST_WAIT_MS 10
`define EPD_SWRST_WAIT_CYC (`EPD_SWRST_WAIT_MS * 1000 * `EPD_CLK_MHZ)
`define EPD_HWRST_US 10
`define EPD_HWRST_CYC (`EPD_HWRST_US * `EPD_CLK_MHZ)
`define EPD_RST_BUSY_US 1000
`define EPD_RST_BUSY_CYC (`EPD_RST_BUSY_US * `EPD_CLK_MHZ)
`define EPD_CLR_BUSY_US 2000
`define EPD_CLR_BUSY_CYC (`EPD_CLR_BUSY_US * `EPD_CLK_MHZ)
`define EPD_DRV_BUSY_MS 4000
`define EPD_DRV_BUSY_CYC (`EPD_DRV_BUSY_MS * 1000 * `EPD_CLK_MHZ)
`endif

// File: verilog/epd_pkg.sv
// Types shared by both ends of the e-paper command link.
package epd_pkg;
   // Host sequencer states.
   typedef enum logic [2:0] {
      EPD_H_IDLE = 3'b000,
      EPD_H_RST = 3'b001,
      EPD_H_SHIFT = 3'b010,
      EPD_H_END = 3'b011,
      EPD_H_GUARD = 3'b100,
      EPD_H_SWWAIT = 3'b101
   } epd_host_st_t;
   // Host state.
   typedef struct packed {
      epd_host_st_t st;
      logic [31:0] cnt;
      logic [3:0] half;
      logic [2:0] bits;
      logic [7:0] sh;
      logic swrst_sent;
      logic sclk;
      logic cs_n;
      logic dc;
      logic sdin;
      logic res_n;
      logic rst_done;
      logic [7:0] last_cmd;
      logic pwr_off_ok;
      logic ready;
      logic [2:0] bsync;
      logic busy_q;
   } epd_host_state_t;
   // Receiver state.
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] q;
      logic [2:0] cnt;
      logic [7:0] sh;
      logic valid;
      logic is_data;
   } epd_rx_state_t;
   // Controller state.
   typedef struct packed {
      logic [7:0] cmd;
      logic [1:0] idx;
      logic busy;
      logic [31:0] busy_cnt;
      logic deep_sleep_state;
      logic [15:0] gate_mux;
      logic [7:0] gate_scan;
      logic [7:0] entry;
      logic [15:0] xs;
      logic [15:0] xe;
      logic [15:0] ys;
      logic [15:0] ye;
      logic [15:0] xc;
      logic [15:0] yc;
      logic [7:0] border;
      logic [7:0] temp_sel;
      logic [7:0] upd_ctrl;
      logic [31:0] softstart;
      logic ram_we;
      logic ram_sel;
      logic [7:0] ram_data;
      logic [15:0] ram_x;
      logic [15:0] ram_y;
      logic clr_pulse;
      logic clr_sel;
      logic drive_pulse;
   } epd_dev_state_t;
endpackage : epd_pkg

// File: verilog/epd_link_if.sv
// Four-wire serial link between host and display controller.
`timescale 1ns/1ps
`default_nettype none
interface epd_link_if;
   logic sclk;   // Serial clock, made by the host.
   logic cs_n;   // Chip select, active low.
   logic dc;     // High for a data byte, low for a command byte.
   logic sdin;   // Serial data, MSB first.
   logic res_n;  // Hardware reset, active low.
   logic busy;   // Controller busy, active high.
   modport host (output sclk, output cs_n, output dc, output sdin, output res_n, input busy);
   modport dev (input sclk, input cs_n, input dc, input sdin, input res_n, output busy);
endinterface : epd_link_if
`default_nettype wire

// File: verilog/epd_rx.sv
// Pin synchroniser and byte deserialiser for the controller end.
`timescale 1ns/1ps
`default_nettype none
`include "epd_defs.svh"
module epd_rx (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Raw pins.
   input wire logic [4:0] pins,
   // Received bytes.
   output logic byte_valid,
   output logic [7:0] byte_data,
   output logic byte_is_data,
   output logic hw_rst
);
   epd_pkg::epd_rx_state_t r_reg;   // Registered state.
   epd_pkg::epd_rx_state_t r_next;  // Next state.

   ////////////////////////////////////////////////////////////////////////
   // Three-stage sync; a pin level counts once stages two and three agree.
   always_comb begin
      r_next = r_reg;
      r_next.s1 = pins;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.valid = 1'b0;
      for (int i = 0; i < 5; i++) begin
         if (r_reg.s2[i] == r_reg.s3[i]) begin
            r_next.q[i] = r_reg.s3[i];
         end
      end
      // Deselect drops any partial byte.
      if (r_next.q[`EPD_PIN_CS]) begin
         r_next.cnt = 3'h0;
      end else if (r_next.q[`EPD_PIN_SCLK] && !r_reg.q[`EPD_PIN_SCLK]) begin
         // Sample on the rising edge, MSB first.
         r_next.sh = {r_reg.sh[6:0], r_next.q[`EPD_PIN_SDIN]};
         r_next.cnt = r_reg.cnt + 3'h1;
         if (r_reg.cnt == 3'h7) begin
            r_next.valid = 1'b1;
            r_next.is_data = r_next.q[`EPD_PIN_DC];
         end
      end
   end

   // Register the state.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         r_reg <= '{s1: `EPD_PIN_IDLE, s2: `EPD_PIN_IDLE, s3: `EPD_PIN_IDLE,
                    q: `EPD_PIN_IDLE, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign byte_valid = r_reg.valid;
   assign byte_data = r_reg.sh;
   assign byte_is_data = r_reg.is_data;
   assign hw_rst = !r_reg.q[`EPD_PIN_RES];
endmodule : epd_rx
`default_nettype wire

// File: verilog/epd_host.sv
// Host end: sends command and data bytes, pulses reset and paces on busy.
`timescale 1ns/1ps
`default_nettype none
`include "epd_defs.svh"
module epd_host #(
   parameter logic [31:0] SWRST_WAIT_CYC = `EPD_SWRST_WAIT_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Link.
   epd_link_if.host link,
   // Reset request from the user.
   input wire logic hw_reset_req,
   // Byte request.
   input wire logic tx_valid,
   input wire logic tx_is_data,
   input wire logic [7:0] tx_byte,
   output logic tx_ready,
   // Status.
   output logic reset_done,
   output logic link_busy,
   output logic power_off_ok
);
   epd_pkg::epd_host_state_t r_reg;   // Registered state.
   epd_pkg::epd_host_state_t r_next;  // Next state.
   logic take;                        // Byte accepted this cycle.

   // True at the last cycle of a half period of the serial clock.
   function automatic logic half_done(input logic [3:0] h);
      return h == (`EPD_SCLK_HALF - 4'h1);
   endfunction : half_done

   assign take = tx_valid && r_reg.ready;

   ////////////////////////////////////////////////////////////////////////
   // Sequencer.
   always_comb begin
      r_next = r_reg;
      // Busy pin: three stages, counted once the last two agree.
      r_next.bsync = {r_reg.bsync[1:0], link.busy};
      if (r_reg.bsync[1] == r_reg.bsync[2]) begin
         r_next.busy_q = r_reg.bsync[2];
      end
      unique case (r_reg.st)
         epd_pkg::EPD_H_IDLE: begin
            if (take) begin
               // Select and set up the first bit a half period early.
               r_next.st = epd_pkg::EPD_H_SHIFT;
               r_next.cs_n = 1'b0;
               r_next.dc = tx_is_data;
               r_next.sh = tx_byte;
               r_next.sdin = tx_byte[7];
               r_next.half = 4'h0;
               r_next.bits = 3'h0;
               r_next.swrst_sent = !tx_is_data && (tx_byte == `EPD_CMD_SWRST);
               if (!tx_is_data) begin
                  r_next.last_cmd = tx_byte;
               end else if (r_reg.last_cmd == `EPD_CMD_DEEP_SLEEP && tx_byte != 8'h00) begin
                  r_next.pwr_off_ok = 1'b1;
               end
            end else if (hw_reset_req) begin
               // Drop the reset pin; bytes wait until it is released and the recovery time after it has passed.
               r_next.st = epd_pkg::EPD_H_RST;
               r_next.res_n = 1'b0;
               r_next.rst_done = 1'b0;
               r_next.pwr_off_ok = 1'b0;
               r_next.cnt = `EPD_HWRST_CYC;
            end
         end
         epd_pkg::EPD_H_RST: begin
            r_next.cnt = r_reg.cnt - 32'h1;
            if (r_reg.cnt <= 32'h1) begin
               // Release, then allow the same time for recovery.
               r_next.res_n = 1'b1;
               r_next.rst_done = 1'b1;
               r_next.st = epd_pkg::EPD_H_GUARD;
               r_next.cnt = `EPD_HWRST_CYC;
            end
         end
         epd_pkg::EPD_H_SHIFT: begin
            r_next.half = r_reg.half + 4'h1;
            if (half_done(r_reg.half)) begin
               r_next.half = 4'h0;
               if (!r_reg.sclk) begin
                  // Rising edge: the controller samples here.
                  r_next.sclk = 1'b1;
               end else begin
                  // Falling edge: present the next bit.
                  r_next.sclk = 1'b0;
                  if (r_reg.bits == 3'h7) begin
                     r_next.st = epd_pkg::EPD_H_END;
                  end else begin
                     r_next.bits = r_reg.bits + 3'h1;
                     r_next.sh = {r_reg.sh[6:0], 1'b0};
                     r_next.sdin = r_reg.sh[6];
                  end
               end
            end
         end
         epd_pkg::EPD_H_END: begin
            // Hold select a half period after the last falling edge.
            r_next.half = r_reg.half + 4'h1;
            if (half_done(r_reg.half)) begin
               r_next.half = 4'h0;
               r_next.cs_n = 1'b1;
               r_next.st = epd_pkg::EPD_H_GUARD;
               r_next.cnt = `EPD_GUARD_CYC;
            end
         end
         epd_pkg::EPD_H_GUARD: begin
            // Gives the controller time to raise busy before it is sampled.
            r_next.cnt = r_reg.cnt - 32'h1;
            if (r_reg.cnt <= 32'h1) begin
               if (r_reg.swrst_sent) begin
                  r_next.st = epd_pkg::EPD_H_SWWAIT;
                  r_next.cnt = SWRST_WAIT_CYC;
                  r_next.swrst_sent = 1'b0;
               end else begin
                  r_next.st = epd_pkg::EPD_H_IDLE;
               end
            end
         end
         epd_pkg::EPD_H_SWWAIT: begin
            // Fixed pause after software reset.
            r_next.cnt = r_reg.cnt - 32'h1;
            if (r_reg.cnt <= 32'h1) begin
               r_next.st = epd_pkg::EPD_H_IDLE;
            end
         end
         default: begin
            r_next.st = epd_pkg::EPD_H_IDLE;
         end
      endcase
      // Ready only when idle, out of reset and the controller is not busy.
      r_next.ready = (r_next.st == epd_pkg::EPD_H_IDLE) && r_next.rst_done
                     && !r_next.busy_q && !hw_reset_req;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register the state; the link starts in four-wire idle.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         r_reg <= '{st: epd_pkg::EPD_H_IDLE, cs_n: 1'b1, res_n: 1'b1,
                    default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign link.sclk = r_reg.sclk;
   assign link.cs_n = r_reg.cs_n;
   assign link.dc = r_reg.dc;
   assign link.sdin = r_reg.sdin;
   assign link.res_n = r_reg.res_n;
   assign tx_ready = r_reg.ready;
   assign reset_done = r_reg.rst_done;
   assign link_busy = r_reg.busy_q;
   assign power_off_ok = r_reg.pwr_off_ok;
endmodule : epd_host
`default_nettype wire

// File: dv/epd_link_sva.sv
// Checker for the serial link between the two ends.
`timescale 1ns/1ps
`default_nettype none
module epd_link_sva #(
   parameter int SWRST_WAIT_CYC = 50,
   parameter int HWRST_CYC = 1000,
   parameter int RST_BUSY_CYC = 20,
   parameter int CLR_BUSY_CYC = 30,
   parameter int DRV_BUSY_CYC = 40
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Link wires.
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic dc,
   input wire logic sdin,
   input wire logic res_n,
   input wire logic busy
);
   //////////////////////////////
   logic sclk_q, done, byte_dc, clr_armed; // Byte recovery state.
   logic [2:0] bits; // Bits taken in the current byte.
   logic [7:0] sh; // Byte as it is shifted in.
   logic [15:0] gap; // Cycles since a software reset byte ended.
   logic [31:0] low_len, busy_len; // Reset pulse and busy spell lengths.
   // Rebuilds bytes and times the fixed spells.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         {sclk_q, done, byte_dc, clr_armed, bits, sh, low_len, busy_len} <= '0;
         gap <= 16'hFFFF;
      end else begin
         sclk_q <= sclk;
         done <= !cs_n && sclk && !sclk_q && bits == 3'h7;
         if (cs_n) begin
            bits <= 3'h0;
         end else if (sclk && !sclk_q) begin
            sh <= {sh[6:0], sdin};
            bits <= bits + 3'h1;
            byte_dc <= dc;
         end
         if (done) begin
            clr_armed <= !byte_dc && (sh == 8'h46 || sh == 8'h47);
         end
         gap <= (done && !byte_dc && sh == 8'h12) ? 16'h0 : gap + 16'(gap != 16'hFFFF);
         low_len <= res_n ? 32'h0 : low_len + 32'h1;
         busy_len <= busy ? busy_len + 32'h1 : 32'h0;
      end
   end
   //////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // A finished command or data byte of a kind that starts a busy spell.
   sequence s_swrst; done && !byte_dc && sh == 8'h12; endsequence
   sequence s_clear; done && byte_dc && sh == 8'hF7 && clr_armed; endsequence
   sequence s_act; done && !byte_dc && sh == 8'h20; endsequence
   a_swrst_busy_rise: assert property (s_swrst |-> ##[1:12] busy)
      else $error("no busy after reset");
   a_clear_busy_rise: assert property (s_clear |-> ##[1:12] busy)
      else $error("no busy after clear");
   a_drive_busy_rise: assert property (s_act |-> ##[1:12] busy)
      else $error("no busy after drive");
   a_busy_spell_len: assert property ($fell(busy) |-> busy_len == RST_BUSY_CYC ||
      busy_len == CLR_BUSY_CYC || busy_len == DRV_BUSY_CYC) else $error("bad busy length");
   a_busy_no_select: assert property ($fell(cs_n) |-> !busy)
      else $error("select while busy");
   a_swrst_quiet: assert property ($fell(cs_n) |-> gap >= SWRST_WAIT_CYC)
      else $error("early byte after reset");
   a_reset_pulse_len: assert property ($rose(res_n) |-> low_len == HWRST_CYC)
      else $error("bad reset length");
   a_reset_quiet: assert property (!res_n |-> cs_n && !sclk)
      else $error("traffic in reset");
   a_sclk_idle_low: assert property (cs_n |-> !sclk)
      else $error("clock while idle");
   a_frame_setup: assert property ($fell(cs_n) |-> !sclk [*3])
      else $error("clock too early");
   a_sdin_hold: assert property (sclk && $past(sclk) |-> $stable(sdin))
      else $error("data moved");
   a_dc_steady: assert property (!cs_n && !$past(cs_n) |-> $stable(dc))
      else $error("flag moved");
endmodule : epd_link_sva
`default_nettype wire

// File: dv/epaper_power_on_update_flow_tb_top.sv
// Bench top: both ends on one link.
`timescale 1ns/1ps
`default_nettype none
module epaper_power_on_update_flow_tb_top;
   //////////////////////////////
   logic mclk = 1'b0, rstn = 1'b0, hw_reset_req = 1'b0, tx_valid = 1'b0, tx_is_data = 1'b0;
   logic [7:0] tx_byte = 8'h00;
   logic tx_ready, reset_done, link_busy, power_off_ok, deep_sleep_state;
   logic [15:0] gate_mux, x_start, x_end, y_start, y_end, ram_x, ram_y;
   logic [7:0] gate_scan, entry_mode, border_cfg, temperature_sensor, update_ctrl, ram_data;
   logic [31:0] softstart_cfg;
   logic ram_we, ram_sel, clear_pulse, clear_sel, drive_pulse;
   int errors = 0, compares = 0;
   int clr_cnt = 0, drv_cnt = 0; // Clear and drive pulses seen.
   logic clr_sel_q = 1'b0; // Selection of the last clear.
   logic busy_seen = 1'b0; // Set whenever busy is seen high.
   logic [40:0] ram_q[$]; // Each RAM write as select, x, y, data.
   logic [31:0] seed = 32'h4C107B4C;
   logic [31:0] v[8];
   always #5 mclk = ~mclk;
   epd_link_if link ();
   epd_host #(.SWRST_WAIT_CYC(32'h32)) epd_host_inst (.mclk, .rstn, .link, .hw_reset_req,
      .tx_valid, .tx_is_data, .tx_byte, .tx_ready, .reset_done, .link_busy, .power_off_ok);
   epd_dev #(.RST_BUSY_CYC(32'h14), .CLR_BUSY_CYC(32'h1E), .DRV_BUSY_CYC(32'h28))
      epd_dev_inst (.mclk, .rstn, .link, .gate_mux, .gate_scan, .entry_mode, .x_start,
      .x_end, .y_start, .y_end, .border_cfg, .temperature_sensor, .update_ctrl,
      .softstart_cfg, .deep_sleep_state, .ram_we, .ram_sel, .ram_data, .ram_x, .ram_y,
      .clear_pulse, .clear_sel, .drive_pulse);
   epd_link_sva epd_link_sva_inst (.mclk, .rstn, .sclk(link.sclk), .cs_n(link.cs_n),
      .dc(link.dc), .sdin(link.sdin), .res_n(link.res_n), .busy(link.busy));
   //////////////////////////////
   // Watches the pulses half a cycle away from the edge that makes them.
   always @(negedge mclk) begin
      if (clear_pulse === 1'b1) begin
         clr_cnt++;
         clr_sel_q = clear_sel;
      end
      if (drive_pulse === 1'b1) drv_cnt++;
      if (ram_we === 1'b1) ram_q.push_back({ram_sel, ram_x, ram_y, ram_data});
      if (link.busy === 1'b1) busy_seen = 1'b1;
   end
   // Steps the xorshift generator.
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Prints the counts and the verdict, then stops.
   task automatic conclude();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   // Compares one value with its expectation.
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // Waits, bounded, until the host is ready.
   task automatic sync();
      int n = 0;
      while (tx_ready !== 1'b1 && n < 5000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 5000) begin
         errors++;
         conclude();
      end
   endtask : sync
   // Hands one byte to the host for one taking edge.
   task automatic send(input logic is_data, input logic [7:0] b);
      sync();
      tx_valid = 1'b1;
      tx_is_data = is_data;
      tx_byte = b;
      @(posedge mclk);
      #1;
      tx_valid = 1'b0;
   endtask : send
   // Sends a command and its parameter bytes, low byte first.
   task automatic cmd(input logic [7:0] code, input int n, input logic [31:0] val);
      send(1'b0, code);
      for (int i = 0; i < n; i++) send(1'b1, val[8*i +: 8]);
      sync();
   endtask : cmd
   //////////////////////////////
   initial begin
      repeat (8) @(posedge mclk);
      #1 rstn = 1'b1;
      chk("busy", link.busy, 0);
      chk("res_n", link.res_n, 1);
      chk("tx_ready", tx_ready, 0);
      hw_reset_req = 1'b1;
      @(posedge mclk);
      #1 hw_reset_req = 1'b0;
      sync();
      chk("reset_done", reset_done, 1);
      $display("test reset done");
      busy_seen = 1'b0;
      send(1'b0, 8'h12);
      sync();
      chk("swrst_busy", busy_seen, 1);
      chk("busy_low", link.busy, 0);
      chk("link_busy", link_busy, 0);
      $display("test soft reset done");
      // Clears of both RAMs, then a clear with the wrong fill byte.
      for (int i = 0; i < 3; i++) begin
         busy_seen = 1'b0;
         cmd((i == 1) ? 8'h47 : 8'h46, 1, (i == 2) ? 32'h55 : 32'hF7);
         chk("clear_count", clr_cnt, (i == 2) ? 2 : i + 1);
         chk("clear_sel", clr_sel_q, i != 0);
         chk("clear_busy", busy_seen, i != 2);
      end
      $display("test clear done");
      foreach (v[i]) v[i] = rnd();
      v[2] = 32'hFFFF_0000;
      cmd(8'h01, 3, v[0]);
      cmd(8'h11, 1, v[1]);
      cmd(8'h44, 4, v[2]);
      cmd(8'h45, 4, v[3]);
      cmd(8'h3C, 1, v[4]);
      cmd(8'h18, 1, v[5]);
      cmd(8'h0C, 4, v[6]);
      chk("gate", {gate_scan, gate_mux}, v[0][23:0]);
      chk("entry", entry_mode, v[1][7:0]);
      chk("xwin", {x_end, x_start}, v[2]);
      chk("ywin", {y_end, y_start}, v[3]);
      chk("border", border_cfg, v[4][7:0]);
      chk("sensor", temperature_sensor, v[5][7:0]);
      chk("softstart", softstart_cfg, v[6]);
      $display("test settings done");
      cmd(8'h4E, 2, {17'h0, v[7][14:0]});
      cmd(8'h4F, 2, v[7][31:16]);
      send(1'b0, 8'h24);
      send(1'b1, v[0][7:0]);
      send(1'b1, v[1][7:0]);
      cmd(8'h26, 1, v[2][7:0]);
      chk("ram_count", ram_q.size(), 3);
      for (int i = 0; i < 3 && i < ram_q.size(); i++) begin
         chk("ram_xy", ram_q[i][39:8], {1'b0, v[7][14:0] + 15'(i), v[7][31:16]});
         chk("ram_sd", {ram_q[i][40], ram_q[i][7:0]}, {i == 2, v[i][7:0]});
      end
      $display("test image write done");
      // Each pass writes a random update control byte, then activates the drive.
      for (int k = 0; k < 2; k++) begin
         v[0] = rnd();
         cmd(8'h22, 1, v[0]);
         busy_seen = 1'b0;
         cmd(8'h20, 0, 32'h0);
         chk("update_ctrl", update_ctrl, v[0][7:0]);
         chk("drive_count", drv_cnt, k + 1);
         chk("drive_busy", busy_seen, 1);
      end
      $display("test drive done");
      cmd(8'h10, 1, 32'h01);
      chk("sleep", deep_sleep_state, 1);
      chk("power_off_ok", power_off_ok, 1);
      cmd(8'h3C, 1, ~v[4]);
      chk("sleep_border", border_cfg, v[4][7:0]);
      $display("test deep sleep done");
      conclude();
   end
endmodule : epaper_power_on_update_flow_tb_top
`default_nettype wire
